// ===== hdl/wwd_delay.sv
// Restart delay of 256 or 4096 core clocks before counting resumes.
// Assumes start_i is a one-cycle pulse; a new start reloads the delay.
`timescale 1ns/10ps
module wwd_delay
  import wwd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic long_i,
  output logic busy_o,
  output logic done_o
);
  localparam logic [WAKE_W-1:0] SHORT_LOAD = WAKE_W'(WAKE_SHORT_CYCLES - 1);
  localparam logic [WAKE_W-1:0] LONG_LOAD = WAKE_W'(WAKE_LONG_CYCLES - 1);
  logic [WAKE_W-1:0] cnt_reg;
  logic busy_reg;
  wire last = busy_reg & (cnt_reg == '0);
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (start_i) begin
      cnt_reg <= long_i ? LONG_LOAD : SHORT_LOAD;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 1'b1;
      busy_reg <= !last;
    end
  end
  assign busy_o = busy_reg;
  assign done_o = last & !start_i;
endmodule

// ===== hdl/wwd_pkg.sv
// Constants, register map and state type of the windowless watchdog.
// Assumes one 250 MHz core clock and a synchronous active-low reset.
// Functional notes
// (R1) A halt with oscillator interrupt enable 0 and halt-reset option 0 never resets, decrements once, then freezes.
// (R2) Leaving that halt on an external interrupt resumes counting after 256 or 4096 core clocks.
// (R3) A reset that ends a halt leaves the watchdog disabled unless the hardware-watchdog option is set.
// (R4) A halt with oscillator interrupt enable 1 enters active-halt, never resets and stops the counter.
// (R5) Leaving active-halt on an oscillator or external interrupt resumes counting at once.
// (R6) Leaving active-halt through reset resumes counting after 256 or 4096 core clocks; the code always waits 256, as the long-wake option resets to 0.
// (R7) The hardware-watchdog option keeps the watchdog always active and ignores the activation bit.
// (R8) The activation bit in bit 7 is set only by a write of 1 and cleared only by reset.
// (R9) A watchdog reset is possible only while the watchdog is active.
// (R10) The seven-bit counter in bits 6:0 is read/write and decrements every 16384 oscillator clocks.
// (R11) When active, a reset is issued as the counter goes from 40h to 3Fh.
// (R12) The control register sits at index 002Ah and resets to activation 0, counter all ones.
// (R13) Software should reload the counter just before a halt to avoid a reset right after wake-up.
// (R14) The counter decrements even while the watchdog is disabled.
// (R15) A write that leaves the watchdog active with the top counter bit clear resets at once.
// (R16) A halt while active, oscillator interrupt enable 0 and halt-reset option 1 issues a reset.
// (R17) A write loads the counter at once without restarting the prescaler.
package wwd_pkg;
  localparam logic [7:0] CTRL_IDX = 8'h2A;
  localparam logic [7:0] OPT_IDX = 8'h2B;
  localparam logic [7:0] STAT_IDX = 8'h2C;
  localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [9:0] OPT_ADDR = {OPT_IDX, 2'b00};
  localparam logic [9:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam int OPT_HALT_RST_BIT = 0;
  localparam int OPT_HW_BIT = 1;
  localparam int OPT_LONG_BIT = 2;
  localparam logic ACT_RESET = 1'b0;
  localparam logic [6:0] COUNT_RESET = 7'h7F;
  localparam logic [6:0] COUNT_TRIP = 7'h40;
  localparam logic [6:0] COUNT_AFTER_TRIP = 7'h3F;
  localparam int PRESCALE_CYCLES = 16384;
  localparam int WAKE_SHORT_CYCLES = 256;
  localparam int WAKE_LONG_CYCLES = 4096;
  localparam int WAKE_W = 13;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT_ONE,
    ST_FROZEN,
    ST_ACT_HALT,
    ST_DELAY
  } wwd_state_t;
endpackage

// ===== hdl/wwd_prescaler.sv
// Free-running divider giving one enable pulse per watchdog count step.
// Assumes a single clock; never restarted by register writes.
`timescale 1ns/10ps
module wwd_prescaler #(
  parameter int DIV = 16384
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  output logic tick_o
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_reg;
  wire wrap = (cnt_reg == LAST);
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
    end
  end
  assign tick_o = wrap;
endmodule

// ===== hdl/wwd_top.sv
// Watchdog top: AHB-Lite register slave, counter, halt handling, reset request.
// Assumes halt and wake inputs come from core logic on the same clock.
`timescale 1ns/10ps
module wwd_top #(
  parameter int PRESCALE = 16384,
  parameter logic HW_WDG_DEFAULT = 1'b0,
  parameter logic HALT_RST_DEFAULT = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic osc_interrupt_enable_i,
  input wire logic halt_i,
  input wire logic ext_irq_i,
  input wire logic osc_irq_i,
  output logic wdg_reset_o
);
  import wwd_pkg::*;

  wwd_state_t state_reg, state_next;
  logic activation_bit_reg;
  logic [6:0] count_reg, count_next;
  logic halt_reset_option_reg;
  logic hw_option_reg;
  logic long_wake_reg;
  logic boot_reg;
  logic wr_ph_reg, rd_ph_reg;
  logic [9:0] ph_addr_reg;
  logic [31:0] hrdata_reg;
  logic wdg_reset_reg;
  logic tick, dly_busy, dly_done;

  // Bus decode; reads take one wait state so a preceding write is visible
  wire addr_ok = hsel_i & htrans_i[1] & hready_i;
  wire ctrl_wr = wr_ph_reg & (ph_addr_reg == CTRL_ADDR);
  wire opt_wr = wr_ph_reg & (ph_addr_reg == OPT_ADDR);
  wire wr_act = hwdata_i[ACT_BIT];
  wire [6:0] wr_count = hwdata_i[6:0];

  // Hardware option overrides the activation bit
  wire active = activation_bit_reg | hw_option_reg; // [R7] [R9]
  wire dec_en = tick & ((state_reg == ST_RUN) | (state_reg == ST_HALT_ONE)); // [R10] [R14]
  wire halt_cmd = halt_i & (state_reg == ST_RUN);
  wire wd_fire = active & dec_en & (state_reg == ST_RUN) & !ctrl_wr & (count_reg == COUNT_TRIP); // [R11] [R1]
  wire sw_fire = ctrl_wr & (wr_act | active) & !wr_count[TOP_BIT]; // [R15]
  wire halt_fire = halt_cmd & !osc_interrupt_enable_i & halt_reset_option_reg & active; // [R16]
  wire wake_ext = ext_irq_i & ((state_reg == ST_HALT_ONE) | (state_reg == ST_FROZEN));
  wire dly_start = boot_reg | wake_ext; // [R2] [R6]

  wire [31:0] rd_ctrl = {24'h00_0000, activation_bit_reg, count_reg};
  wire [31:0] rd_opt = {29'h0000_0000, long_wake_reg, hw_option_reg, halt_reset_option_reg};
  wire [31:0] rd_stat = {28'h000_0000, dly_busy, state_reg == ST_ACT_HALT,
                         state_reg == ST_FROZEN, active};
  wire [31:0] rd_mux = (ph_addr_reg == CTRL_ADDR) ? rd_ctrl :
                       (ph_addr_reg == OPT_ADDR) ? rd_opt :
                       (ph_addr_reg == STAT_ADDR) ? rd_stat : 32'h0000_0000;

  wwd_prescaler #(.DIV(PRESCALE)) u_presc (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .tick_o(tick)
  );

  wwd_delay u_delay (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .start_i(dly_start),
    .long_i(long_wake_reg),
    .busy_o(dly_busy),
    .done_o(dly_done)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (halt_cmd && osc_interrupt_enable_i) begin
          state_next = ST_ACT_HALT; // [R4]
        end else if (halt_cmd && !halt_fire) begin
          state_next = ST_HALT_ONE; // [R1]
        end
      end
      ST_HALT_ONE: begin
        if (ext_irq_i) begin
          state_next = ST_DELAY;
        end else if (tick) begin
          state_next = ST_FROZEN; // [R1]
        end
      end
      ST_FROZEN: begin
        if (ext_irq_i) begin
          state_next = ST_DELAY; // [R2]
        end
      end
      ST_ACT_HALT: begin
        if (osc_irq_i || ext_irq_i) begin
          state_next = ST_RUN; // [R5]
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  // Write wins over a decrement in the same cycle
  always_comb begin
    count_next = count_reg;
    if (ctrl_wr) begin
      count_next = wr_count; // [R17] [R10]
    end else if (dec_en) begin
      count_next = count_reg - 7'h01; // [R14]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_DELAY; // [R6]
      boot_reg <= 1'b1;
      activation_bit_reg <= ACT_RESET; // [R12] [R3]
      count_reg <= COUNT_RESET; // [R12]
      wdg_reset_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      boot_reg <= 1'b0;
      activation_bit_reg <= activation_bit_reg | (ctrl_wr & wr_act); // [R8]
      count_reg <= count_next;
      wdg_reset_reg <= wd_fire | sw_fire | halt_fire;
    end
  end

  // Option bits; hardware option is fixed by its strap default
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      halt_reset_option_reg <= HALT_RST_DEFAULT;
      hw_option_reg <= HW_WDG_DEFAULT; // [R3] [R7]
      long_wake_reg <= 1'b0;
    end else if (opt_wr) begin
      halt_reset_option_reg <= hwdata_i[OPT_HALT_RST_BIT];
      long_wake_reg <= hwdata_i[OPT_LONG_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      wr_ph_reg <= 1'b0;
      rd_ph_reg <= 1'b0;
      ph_addr_reg <= 10'h000;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_ph_reg <= addr_ok & hwrite_i;
      rd_ph_reg <= addr_ok & !hwrite_i;
      if (addr_ok) begin
        ph_addr_reg <= haddr_i[9:0];
      end
      if (rd_ph_reg) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = !rd_ph_reg;
  assign hresp_o = 1'b0;
  assign wdg_reset_o = wdg_reset_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_halt_decrement;
    (state_reg == ST_HALT_ONE) && tick && !ext_irq_i && !ctrl_wr;
  endsequence
  sequence s_frozen_after;
    (state_reg == ST_FROZEN) && !wdg_reset_o;
  endsequence

  property p_halt_one;
    s_halt_decrement |=> s_frozen_after ##0 (count_reg == $past(count_reg) - 7'h01);
  endproperty
  a_halt_one: assert property (p_halt_one) else $error("halt step wrong"); // [R1]

  property p_frozen_hold;
    (state_reg == ST_FROZEN) && !ctrl_wr |=> $stable(count_reg) && !wdg_reset_o;
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("frozen counter moved"); // [R1]

  property p_wake_delay;
    (state_reg == ST_FROZEN) && ext_irq_i |=> (state_reg == ST_DELAY)[*8];
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("wake delay skipped"); // [R2]

  property p_act_halt_stop;
    (state_reg == ST_ACT_HALT) && !ctrl_wr |=> $stable(count_reg) && !wdg_reset_o;
  endproperty
  a_act_halt_stop: assert property (p_act_halt_stop) else $error("active-halt counted"); // [R4]

  property p_act_halt_wake;
    (state_reg == ST_ACT_HALT) && osc_irq_i |=> (state_reg == ST_RUN);
  endproperty
  a_act_halt_wake: assert property (p_act_halt_wake) else $error("active-halt wake late"); // [R5]

  property p_reset_values;
    $rose(resetn_i) |-> (count_reg == COUNT_RESET) && (activation_bit_reg == ACT_RESET)
      && (state_reg == ST_DELAY);
  endproperty
  a_reset_values: assert property (@(posedge core_clk_i) p_reset_values) else $error("bad reset state"); // [R12]

  property p_act_sticky;
    activation_bit_reg |=> activation_bit_reg;
  endproperty
  a_act_sticky: assert property (p_act_sticky) else $error("activation cleared"); // [R8]

  property p_no_reset_inactive;
    !active && !(ctrl_wr && wr_act) |=> !wdg_reset_o;
  endproperty
  a_no_reset_inactive: assert property (p_no_reset_inactive) else $error("reset while disabled"); // [R9]

  property p_trip;
    wd_fire |=> wdg_reset_o && (count_reg == COUNT_AFTER_TRIP);
  endproperty
  a_trip: assert property (p_trip) else $error("trip missed"); // [R11]

  property p_free_run;
    (state_reg == ST_RUN) && tick && !ctrl_wr |=> count_reg == $past(count_reg) - 7'h01;
  endproperty
  a_free_run: assert property (p_free_run) else $error("counter stalled"); // [R14] [R10]

  property p_sw_reset;
    ctrl_wr && (wr_act || active) && !wr_count[TOP_BIT] |=> wdg_reset_o;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset missed"); // [R15]

  property p_halt_reset;
    halt_cmd && active && !osc_interrupt_enable_i && halt_reset_option_reg |=> wdg_reset_o;
  endproperty
  a_halt_reset: assert property (p_halt_reset) else $error("halt reset missed"); // [R16]

  property p_load;
    ctrl_wr |=> count_reg == $past(wr_count);
  endproperty
  a_load: assert property (p_load) else $error("write not loaded"); // [R17]

  // Trip with the activation bit still clear proves the option really forces it on
  property p_hw_active;
    hw_option_reg && !activation_bit_reg && dec_en && (state_reg == ST_RUN) && !ctrl_wr
      && (count_reg == COUNT_TRIP) |=> wdg_reset_o;
  endproperty
  a_hw_active: assert property (p_hw_active) else $error("hw option not active"); // [R7]

  property p_read_wait;
    addr_ok && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  property p_write_ready;
    addr_ok && hwrite_i |=> hreadyout_o;
  endproperty
  a_write_ready: assert property (p_write_ready) else $error("write stalled");

  property p_delay_hold;
    (state_reg == ST_DELAY) && !ctrl_wr |=> $stable(count_reg) && !wdg_reset_o;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("counted during restart delay"); // [R2] [R6]

  property p_delay_end;
    (state_reg == ST_DELAY) && dly_done |=> (state_reg == ST_RUN);
  endproperty
  a_delay_end: assert property (p_delay_end) else $error("restart delay did not end"); // [R2] [R6]

  property p_delay_busy;
    dly_start |=> dly_busy[*8];
  endproperty
  a_delay_busy: assert property (p_delay_busy) else $error("restart delay too short"); // [R2] [R6]

  property p_halt_one_wake;
    (state_reg == ST_HALT_ONE) && ext_irq_i |=> (state_reg == ST_DELAY);
  endproperty
  a_halt_one_wake: assert property (p_halt_one_wake) else $error("early wake skipped delay"); // [R2]

  property p_halt_enter;
    halt_cmd && !osc_interrupt_enable_i && !halt_fire |=> (state_reg == ST_HALT_ONE);
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered"); // [R1]

  property p_act_halt_enter;
    halt_cmd && osc_interrupt_enable_i |=> (state_reg == ST_ACT_HALT);
  endproperty
  a_act_halt_enter: assert property (p_act_halt_enter) else $error("active-halt not entered"); // [R4]

  property p_act_halt_ext_wake;
    (state_reg == ST_ACT_HALT) && ext_irq_i |=> (state_reg == ST_RUN);
  endproperty
  a_act_halt_ext_wake: assert property (p_act_halt_ext_wake) else $error("active-halt ext wake late"); // [R5]
endmodule

// ===== sim/wwd_top_tb.sv
// Self-checking bench for the watchdog top: AHB-Lite register access, halts and wakes.
// Assumes the design packages are compiled first; prescaler shortened to 16 clocks, 2 in the strapped copy.
`timescale 1ns/10ps
module wwd_top_tb;
  import wwd_pkg::*;
  localparam int PS = 16;
  logic clk, rstn, hsel, hwrite, osc_en, halt, ext_irq, osc_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hrdy, hresp, wrst, hw_rst;
  int miscompares, checked, rst_cnt, hw_cnt;
  logic [31:0] a, b, c;
  logic [6:0] v;
  wwd_top #(.PRESCALE(PS)) i_wwd_top (.core_clk_i(clk), .resetn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .osc_interrupt_enable_i(osc_en),
    .halt_i(halt), .ext_irq_i(ext_irq), .osc_irq_i(osc_irq), .wdg_reset_o(wrst));
  // Strapped copy, never written, so only the option can make it trip
  wwd_top #(.PRESCALE(2), .HW_WDG_DEFAULT(1'b1)) i_wwd_top_hw (.core_clk_i(clk), .resetn_i(rstn), .hsel_i(1'b0),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(1'b1),
    .hrdata_o(), .hreadyout_o(), .hresp_o(), .osc_interrupt_enable_i(osc_en), .halt_i(halt), .ext_irq_i(ext_irq),
    .osc_irq_i(osc_irq), .wdg_reset_o(hw_rst));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulses are one cycle wide, so counting edges counts events
  always @(posedge clk) begin
    if (wrst === 1'b1) rst_cnt++;
    if (hw_rst === 1'b1) hw_cnt++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic addr_ph(input logic [9:0] ad, input logic wr);
    @(posedge clk);
    htrans <= 2'b10;
    haddr <= {22'h0, ad};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
  endtask
  task automatic wr(input logic [9:0] ad, input logic [7:0] d);
    addr_ph(ad, 1'b1);
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hrdy !== 1'b1);
  endtask
  task automatic rd(input logic [9:0] ad, output logic [31:0] d);
    addr_ph(ad, 1'b0);
    do @(posedge clk); while (hrdy !== 1'b1);
    d = hrdata;
  endtask
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) halt <= 1'b1;
    else if (which == 1) ext_irq <= 1'b1;
    else osc_irq <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    ext_irq <= 1'b0;
    osc_irq <= 1'b0;
  endtask
  task automatic do_reset(input int hold);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (hold) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One or two ticks may land between a write and its readback
  function automatic logic near(input logic [6:0] w, input logic [31:0] g);
    return (g[6:0] == w) || (g[6:0] == w - 7'd1) || (g[6:0] == w - 7'd2);
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    rstn = 1'b0; hsel = 1'b1; hwrite = 1'b0; osc_en = 1'b0; halt = 1'b0; ext_irq = 1'b0; osc_irq = 1'b0;
    haddr = '0; hwdata = '0; htrans = 2'b00; hsize = 3'b010;
    miscompares = 0; checked = 0; rst_cnt = 0; hw_cnt = 0;
    void'($urandom(64833));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(CTRL_ADDR, a);
    chk("ctrl reset", 32'h0000_007F, a);
    chk("hresp okay", 1'b0, hresp);
    rd(10'h3FC, a);
    chk("unmapped read", 32'h0000_0000, a);
    repeat (400) @(posedge clk);
    rd(CTRL_ADDR, a);
    chk("free run", 1'b1, a[6:0] < 7'h7F);
    for (int i = 0; i < 8; i++) begin
      v = {1'b1, 6'($urandom)};
      wr(CTRL_ADDR, {1'b0, v});
      rd(CTRL_ADDR, a);
      chk("count load", 1'b1, near(v, a) && a[7] == 1'b0);
    end
    v = 7'h41;
    b = rst_cnt;
    wr(CTRL_ADDR, {1'b0, v});
    repeat (4 * PS) @(posedge clk);
    chk("no trip inactive", b, rst_cnt);
    $display("test registers done");
    wr(CTRL_ADDR, 8'hC1);
    wr(CTRL_ADDR, 8'h7F);
    rd(CTRL_ADDR, a);
    chk("act sticky", 1'b1, a[7]);
    b = rst_cnt;
    wr(CTRL_ADDR, 8'hC1);
    repeat (3 * PS) @(posedge clk);
    chk("trip 40 to 3F", b + 1, rst_cnt);
    b = rst_cnt;
    wr(CTRL_ADDR, 8'hBF);
    repeat (3) @(posedge clk);
    chk("soft reset", b + 1, rst_cnt);
    chk("hw always active", 1'b1, hw_cnt > 0);
    $display("test trips done");
    osc_en <= 1'b1;
    wr(CTRL_ADDR, 8'hF0);
    pulse(0);
    repeat (20) @(posedge clk);
    rd(CTRL_ADDR, a);
    repeat (100) @(posedge clk);
    rd(CTRL_ADDR, b);
    chk("active halt frozen", a, b);
    pulse(2);
    repeat (3 * PS) @(posedge clk);
    rd(CTRL_ADDR, c);
    chk("osc wake resumes", 1'b1, c[6:0] != a[6:0]);
    pulse(0);
    repeat (10) @(posedge clk);
    do_reset(2);
    repeat (150) @(posedge clk);
    rd(CTRL_ADDR, a);
    chk("reset wake delay", 32'h0000_007F, a);
    osc_en <= 1'b0;
    // Counting resumes once the restart delay has run out
    repeat (150) @(posedge clk);
    rd(CTRL_ADDR, c);
    chk("reset wake resumes", 1'b1, c[6:0] != 7'h7F);
    $display("test active halt done");
    wr(CTRL_ADDR, 8'hF0);
    b = rst_cnt;
    pulse(0);
    repeat (3 * PS) @(posedge clk);
    rd(CTRL_ADDR, a);
    chk("halt one step", 1'b1, near(7'h6F, a));
    repeat (100) @(posedge clk);
    rd(CTRL_ADDR, c);
    chk("halt frozen", a, c);
    pulse(1);
    repeat (200) @(posedge clk);
    rd(CTRL_ADDR, c);
    chk("ext wake delay", a, c);
    repeat (150) @(posedge clk);
    rd(CTRL_ADDR, c);
    chk("ext wake resumes", 1'b1, c[6:0] != a[6:0]);
    chk("no halt reset", b, rst_cnt);
    wr(OPT_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'hFF);
    b = rst_cnt;
    pulse(0);
    repeat (4) @(posedge clk);
    chk("halt reset", b + 1, rst_cnt);
    do_reset(2);
    @(posedge clk);
    rd(CTRL_ADDR, a);
    chk("act cleared", 1'b0, a[7]);
    b = hw_cnt;
    wr(OPT_ADDR, 8'h04);
    repeat (500) @(posedge clk);
    chk("hw active after reset", 1'b1, hw_cnt > b);
    wr(CTRL_ADDR, 8'h7F);
    pulse(0);
    repeat (3 * PS) @(posedge clk);
    rd(CTRL_ADDR, a);
    pulse(1);
    repeat (2000) @(posedge clk);
    rd(CTRL_ADDR, c);
    chk("long wake delay", a, c);
    repeat (2300) @(posedge clk);
    rd(CTRL_ADDR, c);
    chk("long wake resumes", 1'b1, c[6:0] != a[6:0]);
    $display("test long wake done");
    $display("test halt done");
    finish_test();
  end
endmodule
